// ### rs485_host_model.sv
// host station model on the far side of the rs485 line
// assumes the bench gives the bit time in clock cycles; the line idles high
`timescale 1ns/10ps
module rs485_host_model #(
   parameter int BIT_CYC = 1085
) (
   input  wire logic clk_in,
   input  wire logic txd_in,
   input  wire logic de_in,
   output logic      rxd_out
);
   int cyc       = 0;
   int mid_stop  = 0;
   int start_cyc = 0;
   initial rxd_out = 1'b1;
   always @(posedge clk_in) cyc <= cyc + 1;
   task automatic hold(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   ////////////////////////////////////////////////
   // framed character out
   task automatic send(input logic [7:0] d, input int nb, input logic [1:0] par, input int ns, input logic bad);
      rxd_out <= 1'b0;
      hold(BIT_CYC);
      for (int i = 0; i < nb; i++) begin
         rxd_out <= d[i];
         hold(BIT_CYC);
      end
      if (par != 2'h2) begin
         rxd_out <= ^(d & (nb == 7 ? 8'h7f : 8'hff)) ^ par[0] ^ bad;
         hold(BIT_CYC);
      end
      mid_stop = cyc + BIT_CYC / 2;
      rxd_out <= 1'b1;
      hold(BIT_CYC * ns);
   endtask
   task automatic recv(input int nb, input logic [1:0] par, input int ns, output logic [7:0] d,
                       output logic p, output logic [1:0] st, output logic de_end, output logic ok);
      int n;
      n = 0;
      d = 8'h00;
      p = 1'b0;
      st = 2'h0;
      while (txd_in !== 1'b0 && n < 40000) begin
         hold(1);
         n++;
      end
      start_cyc = cyc;
      hold(BIT_CYC / 2);
      ok = (txd_in === 1'b0);
      for (int i = 0; i < nb; i++) begin
         hold(BIT_CYC);
         d[i] = txd_in;
      end
      if (par != 2'h2) begin
         hold(BIT_CYC);
         p = txd_in;
      end
      for (int i = 0; i < ns; i++) begin
         hold(BIT_CYC);
         st[i] = txd_in;
      end
      hold(BIT_CYC);
      de_end = de_in;
   endtask
endmodule

// ### rs485_serial_port_setup.sv
// configurable rs485 serial port with apb register access
// assumes an external transceiver driven by txd_out and de_out, and rxd_in synchronous to clk_in
`timescale 1ns/10ps
module rs485_serial_port_setup #(
   parameter int MS_CYCLES = serial_port_pkg::MS_CYCLES
) (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic [3:0]  pstrb_in,
   output logic             pready_out,
   output logic             pslverr_out,
   output logic [31:0]      prdata_out,
   // rs485 line
   input  wire logic        rxd_in,
   output logic             txd_out,
   output logic             de_out,
   // settings for the framing layer above
   output logic [1:0]       protocol_out,
   output logic [6:0]       station_addr_out
);

   initial begin
      if (MS_CYCLES < 2 || MS_CYCLES > 1_000_000) $error("rs485_serial_port_setup: MS_CYCLES out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb decode; zero wait states
   wire logic setup_w  = psel_in && !penable_in;
   wire logic access_w = psel_in && penable_in;
   wire logic wr_w     = access_w && pwrite_in;
   wire logic rd_w     = access_w && !pwrite_in;
   wire logic hit_cfg  = (paddr_in == serial_port_pkg::OFS_CONFIG);
   wire logic hit_sta  = (paddr_in == serial_port_pkg::OFS_STATION);
   wire logic hit_rsp  = (paddr_in == serial_port_pkg::OFS_RESP);
   wire logic hit_st   = (paddr_in == serial_port_pkg::OFS_STATUS);
   wire logic hit_rx   = (paddr_in == serial_port_pkg::OFS_RXDATA);
   wire logic hit_tx   = (paddr_in == serial_port_pkg::OFS_TXDATA);
   wire logic mapped   = hit_cfg || hit_sta || hit_rsp || hit_st || hit_rx || hit_tx;

   // fields as written
   wire logic [1:0] w_proto = pwdata_in[serial_port_pkg::CF_PROTO_HI:serial_port_pkg::CF_PROTO_LO];
   wire logic [2:0] w_baud  = pwdata_in[serial_port_pkg::CF_BAUD_HI:serial_port_pkg::CF_BAUD_LO];
   wire logic [1:0] w_par   = pwdata_in[serial_port_pkg::CF_PAR_HI:serial_port_pkg::CF_PAR_LO];
   wire logic [7:0] w_resp  = pwdata_in[7:0];

   // invalid codes are refused whole, old values kept
   wire logic cfg_bad  = (w_proto > serial_port_pkg::PROTO_MAX) || (w_baud > serial_port_pkg::BAUD_MAX)
                         || (w_par > serial_port_pkg::PAR_NONE);
   wire logic resp_bad = (w_resp < serial_port_pkg::RESP_MIN) || (w_resp > serial_port_pkg::RESP_MAX);

   ////////////////////////////////////////////////////////////////////////////
   // settings registers
   logic [1:0] proto_reg;
   logic [2:0] baud_reg;
   logic       len8_reg;
   logic [1:0] par_reg;
   logic       stop2_reg;
   logic [6:0] station_reg;
   logic [7:0] resp_reg;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         proto_reg   <= serial_port_pkg::PROTO_RST;
         baud_reg    <= serial_port_pkg::BAUD_RST;
         len8_reg    <= serial_port_pkg::LEN_RST;
         par_reg     <= serial_port_pkg::PAR_RST;
         stop2_reg   <= serial_port_pkg::STOP_RST;
         station_reg <= serial_port_pkg::STATION_RST;
         resp_reg    <= serial_port_pkg::RESP_RST;
      end else if (wr_w) begin
         if (hit_cfg && !cfg_bad && pstrb_in == 4'hf) begin
            proto_reg <= w_proto;
            baud_reg  <= w_baud;
            len8_reg  <= pwdata_in[serial_port_pkg::CF_LEN];
            par_reg   <= w_par;
            stop2_reg <= pwdata_in[serial_port_pkg::CF_STOP];
         end
         if (hit_sta && pstrb_in[0]) station_reg <= pwdata_in[6:0];
         if (hit_rsp && pstrb_in[0] && !resp_bad) resp_reg <= w_resp;
      end
   end

   wire logic enabled_w = (station_reg != 7'h00);
   assign protocol_out     = proto_reg;
   assign station_addr_out = station_reg;

   ////////////////////////////////////////////////////////////////////////////
   // character engine
   logic       tx_busy;
   logic       rx_done;
   logic [7:0] rx_data;
   logic       rx_perr;
   logic       rx_ferr;
   logic       tx_launch;
   logic [7:0] tx_hold_reg;

   serial_char_engine #(
      .DIV_W (serial_port_pkg::DIV_W)
   ) u_engine (
      .clk_in      (clk_in),
      .rst_in      (rst_in),
      .enable_in   (enabled_w),
      .div_in      (serial_port_pkg::baud_div(baud_reg)),
      .len8_in     (len8_reg),
      .parity_in   (par_reg),
      .stop2_in    (stop2_reg),
      .tx_start_in (tx_launch),
      .tx_data_in  (tx_hold_reg),
      .tx_busy_out (tx_busy),
      .txd_out     (txd_out),
      .rxd_in      (rxd_in),
      .rx_done_out (rx_done),
      .rx_data_out (rx_data),
      .rx_perr_out (rx_perr),
      .rx_ferr_out (rx_ferr)
   );

   assign de_out = tx_busy;

   ////////////////////////////////////////////////////////////////////////////
   // response delay: whole milliseconds since the last received character;
   // strict compare keeps the wait at or above the setting despite mid-stop timing
   logic [31:0] ms_pre_reg;
   logic [7:0]  elapsed_reg;
   wire logic   ms_tick = (ms_pre_reg == 32'(MS_CYCLES - 1));
   wire logic   resp_ok = (elapsed_reg > resp_reg);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ms_pre_reg  <= 32'h0;
         elapsed_reg <= serial_port_pkg::ELAPSED_SAT;
      end else if (rx_done) begin
         ms_pre_reg  <= 32'h0;
         elapsed_reg <= 8'h00;
      end else begin
         ms_pre_reg <= ms_tick ? 32'h0 : ms_pre_reg + 32'h1;
         if (ms_tick && elapsed_reg != serial_port_pkg::ELAPSED_SAT) elapsed_reg <= elapsed_reg + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit holding and receive flags; hardware set wins over software clear, except for overrun, which a read clears even as a character lands
   logic tx_pend_reg;
   logic rx_full_reg;
   logic perr_reg;
   logic ferr_reg;
   logic ovr_reg;
   logic [7:0] rx_buf_reg;

   wire logic tx_wr   = wr_w && hit_tx && pstrb_in[0] && !tx_pend_reg && enabled_w;
   wire logic rx_pop  = rd_w && hit_rx;
   assign tx_launch   = tx_pend_reg && !tx_busy && resp_ok && enabled_w;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_pend_reg <= 1'b0;
         tx_hold_reg <= 8'h00;
         rx_full_reg <= 1'b0;
         perr_reg    <= 1'b0;
         ferr_reg    <= 1'b0;
         ovr_reg     <= 1'b0;
         rx_buf_reg  <= 8'h00;
      end else begin
         if (tx_wr) tx_hold_reg <= pwdata_in[7:0];
         tx_pend_reg <= tx_wr || (tx_pend_reg && !tx_launch && enabled_w);
         rx_full_reg <= rx_done || (rx_full_reg && !rx_pop);
         ovr_reg     <= (rx_done && rx_full_reg && !rx_pop) || (ovr_reg && !rx_pop);
         if (rx_done) begin
            rx_buf_reg <= rx_data;
            perr_reg   <= rx_perr;
            ferr_reg   <= rx_ferr;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data captured in the setup cycle, held through the access cycle
   wire logic [31:0] cfg_rd = (32'(proto_reg) << serial_port_pkg::CF_PROTO_LO)
                            | (32'(baud_reg) << serial_port_pkg::CF_BAUD_LO)
                            | (32'(len8_reg) << serial_port_pkg::CF_LEN)
                            | (32'(par_reg) << serial_port_pkg::CF_PAR_LO)
                            | (32'(stop2_reg) << serial_port_pkg::CF_STOP);
   wire logic [31:0] st_rd  = (32'(enabled_w) << serial_port_pkg::ST_ENABLED)
                            | (32'(tx_busy) << serial_port_pkg::ST_TX_BUSY)
                            | (32'(tx_pend_reg) << serial_port_pkg::ST_TX_PEND)
                            | (32'(rx_full_reg) << serial_port_pkg::ST_RX_FULL)
                            | (32'(perr_reg) << serial_port_pkg::ST_PAR_ERR)
                            | (32'(ferr_reg) << serial_port_pkg::ST_FRM_ERR)
                            | (32'(ovr_reg) << serial_port_pkg::ST_OVERRUN)
                            | (32'(resp_ok) << serial_port_pkg::ST_RESP_OK);
   wire logic [31:0] rd_mux = hit_cfg ? cfg_rd
                            : hit_sta ? {25'h0, station_reg}
                            : hit_rsp ? {24'h0, resp_reg}
                            : hit_st  ? st_rd
                            : hit_rx  ? {24'h0, rx_buf_reg}
                            : 32'h0;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) prdata_out <= 32'h0;
      else if (setup_w && !pwrite_in) prdata_out <= rd_mux;
   end

   assign pready_out  = 1'b1;
   assign pslverr_out = access_w && (!mapped || (pwrite_in && ((hit_cfg && cfg_bad) || (hit_rsp && resp_bad)
                        || (hit_tx && (tx_pend_reg || !enabled_w)) || hit_st || hit_rx)));

endmodule

// ### rs485_serial_port_setup_props.sv
// assertion checker for the rs485 serial port top module
// assumes a well-behaved apb master; sees top module ports only
`timescale 1ns/10ps
module rs485_serial_port_setup_props #(
   parameter int MS_CYCLES = 125000
) (
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [7:0]  paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0]  pstrb_in,
   input wire logic        pslverr_out,
   input wire logic        txd_out,
   input wire logic        de_out,
   input wire logic [1:0]  protocol_out,
   input wire logic [6:0]  station_addr_out
);
   wire wr_acc = psel_in & penable_in & pwrite_in;
   wire cfg_wr = wr_acc & (paddr_in == 8'h00);
   wire stn_wr = wr_acc & (paddr_in == 8'h04);
   wire rsp_wr = wr_acc & (paddr_in == 8'h08);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   ////////////////////////////////////////////////
   proto_bad_a: assert property (cfg_wr && pwdata_in[1:0] == 2'h3 |-> pslverr_out)
      else $error("bad protocol code accepted");
   proto_load_a: assert property (cfg_wr && pstrb_in == 4'hf && !pslverr_out |=>
      protocol_out == $past(pwdata_in[1:0])) else $error("protocol not loaded");
   stn_load_a: assert property (stn_wr && pstrb_in[0] |=> station_addr_out == $past(pwdata_in[6:0]))
      else $error("station not loaded");
   stn_off_a: assert property (station_addr_out == 7'h00 && !de_out |=> !de_out)
      else $error("disabled port transmitted");
   baud_bad_a: assert property (cfg_wr && pwdata_in[6:4] > 3'h5 |-> pslverr_out)
      else $error("bad speed code accepted");
   par_bad_a: assert property (cfg_wr && pwdata_in[13:12] == 2'h3 |-> pslverr_out)
      else $error("bad parity code accepted");
   resp_bad_a: assert property (rsp_wr && (pwdata_in[7:0] == 8'h00 || pwdata_in[7:0] > 8'hfa) |->
      pslverr_out) else $error("bad response time accepted");
   idle_high_a: assert property (!de_out |-> txd_out)
      else $error("line not idle high");
   start_low_a: assert property ($rose(de_out) |-> !txd_out [*8])
      else $error("start bit missing");
   cover property ($rose(de_out));
   cover property (cfg_wr && !pslverr_out);
   cover property (rsp_wr && pslverr_out);
endmodule
bind rs485_serial_port_setup rs485_serial_port_setup_props #(.MS_CYCLES(MS_CYCLES)) props_i (
   .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
   .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .pslverr_out(pslverr_out),
   .txd_out(txd_out), .de_out(de_out), .protocol_out(protocol_out), .station_addr_out(station_addr_out));

// ### rs485_serial_port_setup_tb_top.sv
// self-checking bench for the rs485 serial port
// assumes the host model on the line; short millisecond for run time
`timescale 1ns/10ps
module rs485_serial_port_setup_tb_top;
   localparam int MS  = 2000;
   localparam int DIV = 125_000_000 / 115200;
   logic        clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        psel   = 1'b0;
   logic        pen    = 1'b0;
   logic        pwr    = 1'b0;
   logic [7:0]  paddr  = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb  = 4'h0;
   logic        pready, perr, rxd, txd, de, e, p, de_end, ok;
   logic [31:0] prdata, r;
   logic [1:0]  proto, st;
   logic [6:0]  stn;
   logic [7:0]  d;
   int          fail_count = 0;
   int          checked    = 0;
   rs485_serial_port_setup #(.MS_CYCLES(MS)) dut (
      .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .pready_out(pready), .pslverr_out(perr),
      .prdata_out(prdata), .rxd_in(rxd), .txd_out(txd), .de_out(de), .protocol_out(proto),
      .station_addr_out(stn));
   rs485_host_model #(.BIT_CYC(DIV)) host (.clk_in(clk_in), .txd_in(txd), .de_in(de), .rxd_out(rxd));
   initial begin
      forever #4 clk_in = ~clk_in;
   end
   ////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s seen %h", $time, m, seen);
      end
   endtask
   // held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= v;
      pstrb  <= w ? 4'hf : 4'h0;
      @(posedge clk_in);
      pen <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = perr;
      psel <= 1'b0;
      pen  <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic ee);
      apb(1'b1, a, v);
      chk(e, ee, "slave error");
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(r, x, "read data");
   endtask
   ////////////////////////////////////////////////
   task automatic t_defaults;
      chk(proto, 2'h0, "protocol");
      chk(stn, 7'h7f, "station");
      rd(8'h00, 32'h120);
      rd(8'h08, 32'h3);
      chk({txd, de}, 2'b10, "idle");
      apb(1'b0, 8'h18, 32'h0);
      chk(e, 1'b1, "unmapped");
   endtask
   task automatic t_codes;
      for (int i = 0; i < 3; i++) begin
         wr(8'h00, 32'h120 | i, 1'b0);
         chk(proto, i, "protocol");
      end
      for (int i = 0; i < 6; i++) begin
         wr(8'h00, 32'h100 | (i << 4), 1'b0);
         rd(8'h00, 32'h100 | (i << 4));
      end
      wr(8'h00, 32'h123, 1'b1);
      wr(8'h00, 32'h160, 1'b1);
      wr(8'h00, 32'h3120, 1'b1);
      rd(8'h00, 32'h150);
      wr(8'h00, 32'h10020, 1'b0);
      rd(8'h00, 32'h10020);
   endtask
   task automatic t_station;
      wr(8'h04, 32'h0, 1'b0);
      apb(1'b0, 8'h0c, 32'h0);
      chk(r[0], 1'b0, "enabled");
      wr(8'h14, 32'h55, 1'b1);
      wr(8'h04, 32'h7f, 1'b0);
      apb(1'b0, 8'h0c, 32'h0);
      chk(r[0], 1'b1, "enabled");
   endtask
   task automatic t_resp;
      wr(8'h08, 32'h0, 1'b1);
      wr(8'h08, 32'hfb, 1'b1);
      wr(8'h08, 32'hfa, 1'b0);
      rd(8'h08, 32'hfa);
   endtask
   task automatic t_tx;
      logic [31:0] cfg [3] = '{32'h150, 32'h11050, 32'h2150};
      logic [7:0]  dat [3] = '{8'ha6, 8'hb5, 8'h3c};
      logic [1:0]  par [3] = '{2'h0, 2'h1, 2'h2};
      int          nb [3]  = '{8, 7, 8};
      int          ns [3]  = '{1, 2, 1};
      logic [7:0]  m;
      for (int i = 0; i < 3; i++) begin
         m = dat[i] & (nb[i] == 7 ? 8'h7f : 8'hff);
         wr(8'h00, cfg[i], 1'b0);
         wr(8'h14, dat[i], 1'b0);
         host.recv(nb[i], par[i], ns[i], d, p, st, de_end, ok);
         chk(ok, 1'b1, "start bit");
         chk(d, m, "data");
         if (par[i] != 2'h2) chk(p, ^m ^ par[i][0], "parity");
         chk(st, ns[i] == 2 ? 2'b11 : 2'b01, "stop");
         chk(de_end, 1'b0, "driver off");
      end
   endtask
   task automatic t_rx;
      wr(8'h00, 32'h11050, 1'b0);
      wr(8'h08, 32'h2, 1'b0);
      host.send(8'hd3, 7, 2'h1, 2, 1'b0);
      repeat (4) @(posedge clk_in);
      rd(8'h10, 32'h53);
      apb(1'b0, 8'h0c, 32'h0);
      chk(r[4], 1'b0, "parity flag");
      host.send(8'h2a, 7, 2'h1, 2, 1'b1);
      repeat (4) @(posedge clk_in);
      apb(1'b0, 8'h0c, 32'h0);
      chk(r[4], 1'b1, "parity flag");
      rd(8'h10, 32'h2a);
      wr(8'h14, 32'h11, 1'b0);
      host.recv(7, 2'h1, 2, d, p, st, de_end, ok);
      chk(d, 8'h11, "reply");
      chk(host.start_cyc - host.mid_stop >= 2 * MS && host.start_cyc - host.mid_stop <= 3 * MS + 20, 1'b1,
          "reply delay");
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      t_defaults;
      t_codes;
      t_station;
      t_resp;
      t_tx;
      t_rx;
      summarize;
   end
   // a hang would otherwise run forever
   initial begin
      #760_000;
      fail_count++;
      summarize;
   end
endmodule

// ### serial_char_engine.sv
// character transmitter and receiver for the rs485 serial port
// assumes rxd is synchronous to clk_in; bit period comes in as a cycle count
`timescale 1ns/10ps
module serial_char_engine #(
   parameter int DIV_W = serial_port_pkg::DIV_W
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // format
   input  wire logic             enable_in,
   input  wire logic [DIV_W-1:0] div_in,
   input  wire logic             len8_in,
   input  wire logic [1:0]       parity_in,
   input  wire logic             stop2_in,
   // transmit side
   input  wire logic             tx_start_in,
   input  wire logic [7:0]       tx_data_in,
   output logic                  tx_busy_out,
   output logic                  txd_out,
   // receive side
   input  wire logic             rxd_in,
   output logic                  rx_done_out,
   output logic [7:0]            rx_data_out,
   output logic                  rx_perr_out,
   output logic                  rx_ferr_out
);

   initial begin
      if (DIV_W < 4 || DIV_W > 24) $error("serial_char_engine: DIV_W out of range");
   end

   typedef enum {RX_IDLE, RX_START, RX_BITS} rx_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // frame shape shared by both directions
   wire logic       par_on    = (parity_in != serial_port_pkg::PAR_NONE);
   wire logic [3:0] data_bits = len8_in ? 4'h8 : 4'h7;
   wire logic [3:0] tx_bits   = 4'h1 + data_bits + {3'h0, par_on} + (stop2_in ? 4'h2 : 4'h1);
   wire logic [3:0] rx_bits   = data_bits + {3'h0, par_on} + 4'h1;
   wire logic [DIV_W-1:0] div_last = div_in - DIV_W'(1);
   wire logic [DIV_W-1:0] div_half = (div_in >> 1) - DIV_W'(1);

   wire logic [7:0] tx_masked = len8_in ? tx_data_in : {1'b0, tx_data_in[6:0]};
   wire logic       tx_par    = (^tx_masked) ^ (parity_in == serial_port_pkg::PAR_ODD);
   wire logic       tx_pbit   = par_on ? tx_par : 1'b1;
   wire logic [11:0] tx_frame = len8_in ? {2'h3, tx_pbit, tx_data_in, 1'b0}
                                        : {3'h7, tx_pbit, tx_data_in[6:0], 1'b0};

   ////////////////////////////////////////////////////////////////////////////
   // transmitter: idle ones keep the line at mark between frames
   logic [11:0]      tx_shift_reg;
   logic [3:0]       tx_left_reg;
   logic [DIV_W-1:0] tx_cnt_reg;

   assign tx_busy_out = (tx_left_reg != 4'h0);
   assign txd_out     = tx_shift_reg[0];

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_shift_reg <= 12'hfff;
         tx_left_reg  <= 4'h0;
         tx_cnt_reg   <= '0;
      end else if (!tx_busy_out) begin
         if (tx_start_in && enable_in) begin
            tx_shift_reg <= tx_frame;
            tx_left_reg  <= tx_bits;
            tx_cnt_reg   <= div_last;
         end
      end else if (tx_cnt_reg == '0) begin
         tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
         tx_left_reg  <= tx_left_reg - 4'h1;
         tx_cnt_reg   <= div_last;
      end else begin
         tx_cnt_reg <= tx_cnt_reg - DIV_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receiver: mid-bit sampling; only the first stop bit is checked
   rx_state_t        rx_state_reg;
   logic [9:0]       rx_shift_reg;
   logic [3:0]       rx_left_reg;
   logic [DIV_W-1:0] rx_cnt_reg;

   wire logic       rx_tick   = (rx_cnt_reg == '0);
   wire logic       rx_last   = (rx_state_reg == RX_BITS) && rx_tick && (rx_left_reg == 4'h1);
   wire logic [9:0] rx_full_w = {rxd_in, rx_shift_reg[9:1]};
   wire logic [9:0] rx_align  = rx_full_w >> (4'ha - rx_bits);
   wire logic [7:0] rx_dat_w  = len8_in ? rx_align[7:0] : {1'b0, rx_align[6:0]};
   wire logic       rx_pbit   = rx_align[data_bits];
   wire logic       rx_pbad   = par_on && ((^rx_dat_w) ^ rx_pbit ^ (parity_in == serial_port_pkg::PAR_ODD));

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_state_reg <= RX_IDLE;
         rx_shift_reg <= '0;
         rx_left_reg  <= 4'h0;
         rx_cnt_reg   <= '0;
      end else if (!enable_in) begin
         rx_state_reg <= RX_IDLE;
      end else begin
         rx_cnt_reg <= rx_tick ? div_last : rx_cnt_reg - DIV_W'(1);
         case (rx_state_reg)
            RX_IDLE: begin
               if (!rxd_in) begin
                  rx_state_reg <= RX_START;
                  rx_cnt_reg   <= div_half;
               end
            end
            RX_START: begin
               if (rx_tick) begin
                  rx_state_reg <= rxd_in ? RX_IDLE : RX_BITS;
                  rx_left_reg  <= rx_bits;
               end
            end
            RX_BITS: begin
               if (rx_tick) begin
                  rx_shift_reg <= rx_full_w;
                  rx_left_reg  <= rx_left_reg - 4'h1;
                  if (rx_left_reg == 4'h1) rx_state_reg <= RX_IDLE;
               end
            end
            default: rx_state_reg <= RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_done_out <= 1'b0;
         rx_data_out <= 8'h00;
         rx_perr_out <= 1'b0;
         rx_ferr_out <= 1'b0;
      end else begin
         rx_done_out <= rx_last && enable_in;
         if (rx_last && enable_in) begin
            rx_data_out <= rx_dat_w;
            rx_perr_out <= rx_pbad;
            rx_ferr_out <= !rxd_in;
         end
      end
   end

endmodule

// ### serial_port_pkg.sv
// constants, register map and field layout of the rs485 serial port
// assumes a 125 mhz system clock and a 32-bit apb register bus
package serial_port_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam int CLK_HZ        = 125_000_000;
   localparam int CLK_PERIOD_NS = 8;
   localparam int MS_NS         = 1_000_000;
   localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
   localparam int DIV_W         = 16;

   ////////////////////////////////////////////////////////////////////////////
   // bit rates selected by the speed code
   localparam int BAUD_0 = 4800;
   localparam int BAUD_1 = 9600;
   localparam int BAUD_2 = 19200;
   localparam int BAUD_3 = 38400;
   localparam int BAUD_4 = 57600;
   localparam int BAUD_5 = 115200;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] OFS_CONFIG  = 8'h00;
   localparam logic [7:0] OFS_STATION = 8'h04;
   localparam logic [7:0] OFS_RESP    = 8'h08;
   localparam logic [7:0] OFS_STATUS  = 8'h0c;
   localparam logic [7:0] OFS_RXDATA  = 8'h10;
   localparam logic [7:0] OFS_TXDATA  = 8'h14;

   ////////////////////////////////////////////////////////////////////////////
   // config field positions
   localparam int CF_PROTO_LO  = 0;
   localparam int CF_PROTO_HI  = 1;
   localparam int CF_BAUD_LO   = 4;
   localparam int CF_BAUD_HI   = 6;
   localparam int CF_LEN       = 8;
   localparam int CF_PAR_LO    = 12;
   localparam int CF_PAR_HI    = 13;
   localparam int CF_STOP      = 16;

   // status bit positions
   localparam int ST_ENABLED   = 0;
   localparam int ST_TX_BUSY   = 1;
   localparam int ST_TX_PEND   = 2;
   localparam int ST_RX_FULL   = 3;
   localparam int ST_PAR_ERR   = 4;
   localparam int ST_FRM_ERR   = 5;
   localparam int ST_OVERRUN   = 6;
   localparam int ST_RESP_OK   = 7;

   ////////////////////////////////////////////////////////////////////////////
   // codes and reset values
   typedef enum logic [1:0] {PROTO_VENDOR = 2'h0, PROTO_ASCII = 2'h1, PROTO_RTU = 2'h2} proto_t;
   localparam logic [1:0] PAR_EVEN     = 2'h0;
   localparam logic [1:0] PAR_ODD      = 2'h1;
   localparam logic [1:0] PAR_NONE     = 2'h2;
   localparam logic [2:0] BAUD_MAX     = 3'h5;
   localparam logic [1:0] PROTO_MAX    = 2'h2;
   localparam logic [1:0] PROTO_RST    = 2'h0;
   localparam logic [2:0] BAUD_RST     = 3'h2;
   localparam logic       LEN_RST      = 1'h1;
   localparam logic [1:0] PAR_RST      = 2'h0;
   localparam logic       STOP_RST     = 1'h0;
   localparam logic [6:0] STATION_RST  = 7'h7f;
   localparam logic [7:0] RESP_RST     = 8'h03;
   localparam logic [7:0] RESP_MIN     = 8'h01;
   localparam logic [7:0] RESP_MAX     = 8'hfa;
   localparam logic [7:0] ELAPSED_SAT  = 8'hff;

   // cycles per bit for a speed code
   function automatic logic [DIV_W-1:0] baud_div(input logic [2:0] code);
      int rate;
      case (code)
         3'h0:    rate = BAUD_0;
         3'h1:    rate = BAUD_1;
         3'h2:    rate = BAUD_2;
         3'h3:    rate = BAUD_3;
         3'h4:    rate = BAUD_4;
         default: rate = BAUD_5;
      endcase
      return DIV_W'(CLK_HZ / rate);
   endfunction

endpackage
